// *** core/video_output_processing_chain.sv ***
`timescale 1ns/100ps
module video_output_processing_chain #(
    parameter int ADDR_W = 10
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    input wire video_chain_pkg::sample_t in_y,
    input wire video_chain_pkg::sample_t in_u,
    input wire video_chain_pkg::sample_t in_v,
    input wire logic in_blank,
    input wire logic pattern_key,
    input wire logic line_sync,
    input wire video_chain_pkg::sample_t slope_limit,
    input wire logic [3:0] edge_width_cap,
    input wire logic luma_graphic_enable,
    input wire logic [1:0] luma_graphic_bits,
    input wire logic chroma_graphic_enable,
    input wire logic [1:0] chroma_graphic_bits,
    input wire logic luma_invert,
    input wire logic u_invert,
    input wire logic v_invert,
    input wire logic compander_enable,
    input wire logic squeeze_stretch_enable,
    input wire logic [8:0] read_step,
    input wire video_chain_pkg::pos_t read_offset,
    input wire logic double_rate_enable,
    input wire logic double_rate_filter_enable,
    input wire video_chain_pkg::sample_t line_sync_delay,
    input wire video_chain_pkg::sample_t black_value,
    input wire logic backdrop_enable,
    input wire video_chain_pkg::sample_t backdrop_luma,
    input wire video_chain_pkg::sample_t backdrop_u,
    input wire video_chain_pkg::sample_t backdrop_v,
    input wire video_chain_pkg::pos_t backdrop_start,
    input wire video_chain_pkg::pos_t backdrop_width,
    input wire video_chain_pkg::sample_t pattern_luma,
    input wire video_chain_pkg::sample_t pattern_u,
    input wire video_chain_pkg::sample_t pattern_v,
    input wire logic pattern_key_polarity,
    input wire logic luma_phase_trim,
    input wire logic luma_half_gain,
    input wire logic u_half_gain,
    input wire logic v_half_gain,
    output logic out_valid,
    output video_chain_pkg::dac_t dac_y,
    output video_chain_pkg::dac_t dac_u,
    output video_chain_pkg::dac_t dac_v
);
    import video_chain_pkg::*;

    if (ADDR_W < 10 || ADDR_W > 12) begin : g_chk
        $error("ADDR_W must hold a full line");
    end

    // Keep b+1 top bits and refill below with their copy, so white stays white
    function automatic sample_t quant(input sample_t x, input logic [1:0] b);
        int n;
        sample_t q;
        sample_t r;
        n = int'(b) + 1;
        q = x & sample_t'(8'hFF << (8 - n));
        r = q;
        for (int i = 1; i < 8; i++) begin
            r = r | sample_t'(q >> (i * n));
        end
        return r;
    endfunction : quant

    function automatic logic [9:0] absd(input logic signed [8:0] d);
        return d[8] ? 10'(-d) : 10'(d);
    endfunction : absd

    function automatic pos_t gain(input pos_t x, input logic f);
        return f ? pos_t'(x + (x >> GAIN_SHIFT)) : x;
    endfunction : gain

    function automatic dac_t clip(input pos_t x, input logic half);
        logic signed [11:0] s;
        s = half ? $signed({2'b00, x}) : $signed({1'b0, x, 1'b0});
        if (s < 0) return 9'h000;
        if (s > $signed({3'b000, OUT_MAX})) return OUT_MAX;
        return s[8:0];
    endfunction : clip

    // Line sync comes from the pin side
    logic ls_s1, ls_s2, ls_s3;
    wire ls_rise = ls_s2 && !ls_s3;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {ls_s1, ls_s2, ls_s3} <= 3'b000;
        end else begin
            {ls_s1, ls_s2, ls_s3} <= {line_sync, ls_s1, ls_s2};
        end
    end

    // Chroma edge sharpener
    sample_t u1_r, v1_r, lu1_r, lv1_r, hu_r, hv_r;
    logic signed [8:0] du1_r, dv1_r;
    logic signed [10:0] d2p_r;
    logic [3:0] wcnt_r;
    logic cross_r;
    wire sample_t lu = 8'((9'(in_u) + 9'(u1_r)) >> 1);
    wire sample_t lv = 8'((9'(in_v) + 9'(v1_r)) >> 1);
    wire logic signed [8:0] du = $signed({1'b0, lu}) - $signed({1'b0, lu1_r});
    wire logic signed [8:0] dv = $signed({1'b0, lv}) - $signed({1'b0, lv1_r});
    wire logic signed [10:0] d2 = 11'(du) - 11'(du1_r) + 11'(dv) - 11'(dv1_r);
    wire zc = d2[10] != d2p_r[10];
    wire steep = absd(du) + absd(dv) > 10'(slope_limit);
    wire region = steep && (wcnt_r < edge_width_cap);
    wire hold = region && !(cross_r || zc);
    wire sample_t su = hold ? ((wcnt_r == 4'h0) ? u1_r : hu_r) : in_u;
    wire sample_t sv = hold ? ((wcnt_r == 4'h0) ? v1_r : hv_r) : in_v;
    wire sample_t gy = luma_graphic_enable ? quant(in_y, luma_graphic_bits) : in_y;
    wire sample_t gu = chroma_graphic_enable ? quant(su, chroma_graphic_bits) : su;
    wire sample_t gv = chroma_graphic_enable ? quant(sv, chroma_graphic_bits) : sv;
    sample_t pre_y, pre_u, pre_v;
    logic pre_k, pre_bl, pre_vld;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {u1_r, v1_r, lu1_r, lv1_r, hu_r, hv_r} <= '0;
            {du1_r, dv1_r, d2p_r, wcnt_r, cross_r} <= '0;
            {pre_y, pre_u, pre_v, pre_k, pre_bl, pre_vld} <= '0;
        end else begin
            pre_vld <= in_valid;
            if (in_valid) begin
                {u1_r, v1_r, lu1_r, lv1_r, du1_r, dv1_r, d2p_r} <= {in_u, in_v, lu, lv, du, dv, d2};
                wcnt_r <= region ? wcnt_r + 4'h1 : 4'h0;
                cross_r <= region && (cross_r || zc);
                if (region && wcnt_r == 4'h0) begin
                    {hu_r, hv_r} <= {u1_r, v1_r};
                end
                pre_y <= luma_invert ? ~gy : gy;
                pre_u <= u_invert ? ~gu : gu;
                pre_v <= v_invert ? ~gv : gv;
                {pre_k, pre_bl} <= {pattern_key, in_blank};
            end
        end
    end

    // Compander: credit pacing stands in for the read clock on one clock edge
    localparam int DEPTH = 1 << ADDR_W;
    logic [24:0] mem [DEPTH];
    logic [ADDR_W-1:0] wa_r, ra_r;
    logic [9:0] cr_r;
    logic [24:0] mq_r;
    logic rd_vld_r;
    wire logic [8:0] st_sq = (read_step > RATE_MAX) ? RATE_MAX :
                             (read_step < RATE_ONE) ? RATE_ONE : read_step;
    wire logic [8:0] st_ex = (read_step < RATE_MIN) ? RATE_MIN :
                             (read_step > RATE_ONE) ? RATE_ONE : read_step;
    wire logic [8:0] rate = squeeze_stretch_enable ? st_sq : st_ex;
    wire rd = compander_enable && cr_r >= 10'(RATE_ONE);
    always_ff @(posedge clock) begin
        if (pre_vld) begin
            mem[wa_r] <= {pre_k, pre_y, pre_u, pre_v};
        end
        mq_r <= mem[ra_r];
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {wa_r, ra_r, cr_r, rd_vld_r} <= '0;
        end else if (ls_rise) begin
            wa_r <= '0;
            ra_r <= ADDR_W'(read_offset);
            cr_r <= 10'h000;
            rd_vld_r <= 1'b0;
        end else begin
            wa_r <= wa_r + ADDR_W'(pre_vld);
            ra_r <= ra_r + ADDR_W'(rd);
            cr_r <= cr_r + (pre_vld ? 10'(rate) : 10'h000) - (rd ? 10'(RATE_ONE) : 10'h000);
            rd_vld_r <= rd;
        end
    end
    // Blanking and disabled compander take the direct path
    wire byp = !compander_enable || pre_bl;
    wire c_vld = byp ? pre_vld : rd_vld_r;
    wire logic [24:0] c_d = byp ? {pre_k, pre_y, pre_u, pre_v} : mq_r;

    // Doubling stage; input must leave a free cycle between samples when doubling
    os_state_t os_r;
    logic [24:0] prev_r, sec_r, os_d;
    logic os_vld;
    wire mid = double_rate_filter_enable;
    wire sample_t my = 8'((9'(prev_r[23:16]) + 9'(c_d[23:16])) >> 1);
    wire sample_t mu = 8'((9'(prev_r[15:8]) + 9'(c_d[15:8])) >> 1);
    wire sample_t mv = 8'((9'(prev_r[7:0]) + 9'(c_d[7:0])) >> 1);
    wire logic [24:0] first = mid ? {c_d[24], my, mu, mv} : c_d;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            os_r <= OS_IDLE;
            {prev_r, sec_r, os_d, os_vld} <= '0;
        end else begin
            case (os_r)
                OS_IDLE: begin
                    os_vld <= c_vld;
                    if (c_vld) begin
                        prev_r <= c_d;
                        sec_r <= c_d;
                        os_d <= double_rate_enable ? first : c_d;
                        if (double_rate_enable) begin
                            os_r <= OS_SECOND;
                        end
                    end
                end
                OS_SECOND: begin
                    os_vld <= 1'b1;
                    os_d <= sec_r;
                    os_r <= OS_IDLE;
                end
                default: os_r <= OS_IDLE;
            endcase
        end
    end
    wire f_on = double_rate_enable && mid;
    wire pos_t oy = gain(10'(os_d[23:16]), f_on);
    wire pos_t ou = gain(10'(os_d[15:8]), f_on);
    wire pos_t ov = gain(10'(os_d[7:0]), f_on);

    // Insertion after doubling
    logic [7:0] dly_r;
    logic dly_run_r;
    logic [6:0] blk_r;
    pos_t pix_r, bd_r;
    wire black_on = blk_r != 7'h00;
    wire key_on = os_d[24] ^ pattern_key_polarity;
    wire bd_start = backdrop_enable && os_vld && pix_r == backdrop_start;
    wire bd_on = backdrop_enable && bd_r != 10'h000;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {dly_r, dly_run_r, blk_r, pix_r, bd_r} <= '0;
        end else begin
            if (ls_rise) begin
                dly_r <= line_sync_delay;
                dly_run_r <= 1'b1;
            end else if (dly_run_r && dly_r != 8'h00) begin
                dly_r <= dly_r - 8'h01;
            end else begin
                dly_run_r <= 1'b0;
            end
            if (dly_run_r && dly_r == 8'h00 && !ls_rise) begin
                blk_r <= BLACK_LOAD;
            end else if (black_on) begin
                blk_r <= blk_r - 7'h01;
            end
            pix_r <= ls_rise ? 10'h000 : pix_r + 10'(os_vld);
            // Runs on across line sync so the area can wrap into the next line
            // Start sample counts as the first of the width
            if (bd_start) begin
                bd_r <= backdrop_width - 10'h001;
            end else if (bd_on && os_vld) begin
                bd_r <= bd_r - 10'h001;
            end
        end
    end
    pos_t ins_y, ins_u, ins_v, ytr_r;
    logic ins_vld;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {ins_y, ins_u, ins_v, ins_vld, ytr_r} <= '0;
        end else begin
            ins_vld <= os_vld;
            if (os_vld) begin
                if (black_on) begin
                    {ins_y, ins_u, ins_v} <= {10'(black_value), 10'(CHROMA_ZERO), 10'(CHROMA_ZERO)};
                end else if (key_on) begin
                    {ins_y, ins_u, ins_v} <= {10'(pattern_luma), 10'(pattern_u), 10'(pattern_v)};
                end else if (bd_on || (bd_start && backdrop_width != 10'h000)) begin
                    {ins_y, ins_u, ins_v} <= {10'(backdrop_luma), 10'(backdrop_u), 10'(backdrop_v)};
                end else begin
                    {ins_y, ins_u, ins_v} <= {oy, ou, ov};
                end
            end
            if (ins_vld) begin
                ytr_r <= ins_y;
            end
        end
    end

    // Output gain and limiter
    wire pos_t yo = luma_phase_trim ? ytr_r : ins_y;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {out_valid, dac_y, dac_u, dac_v} <= '0;
        end else begin
            out_valid <= ins_vld;
            if (ins_vld) begin
                dac_y <= clip(yo, luma_half_gain);
                dac_u <= clip(ins_u, u_half_gain);
                dac_v <= clip(ins_v, v_half_gain);
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_black_span: assert property ($fell(black_on) |-> $past(black_on, 80))
        else $error("black phase too short");
    a_black_delay: assert property (ls_rise && line_sync_delay == 8'h00 |-> ##2 black_on)
        else $error("black phase not started after sync");
    a_black_wins: assert property (os_vld && black_on |=> ins_y == 10'(black_value))
        else $error("black phase overwritten");
    a_key_insert: assert property (os_vld && !black_on && key_on |=> ins_y == 10'(pattern_luma))
        else $error("pattern colour missing");
    a_luma_invert: assert property (in_valid && luma_invert && !luma_graphic_enable
        |=> pre_y == ~$past(in_y))
        else $error("luma not inverted");
    a_graphic_white: assert property (in_valid && luma_graphic_enable && !luma_invert
        && in_y == 8'hFF |=> pre_y == 8'hFF)
        else $error("graphic mode lost brightness");
    a_repeat_pair: assert property (os_r == OS_IDLE && c_vld && double_rate_enable && !mid
        |=> os_vld && os_d == $past(c_d) ##1 os_vld && os_d == $past(c_d, 2))
        else $error("sample not repeated");
    a_limit_top: assert property (ins_vld && !u_half_gain && ins_u > 10'h0FF |=> dac_u == OUT_MAX)
        else $error("limiter did not clip");
    a_half_gain: assert property (ins_vld && u_half_gain && ins_u <= 10'h1FF
        |=> dac_u == $past(ins_u[8:0]))
        else $error("half gain wrong");
    c_black: cover property (black_on && bd_on);
    c_compander: cover property (rd && !byp);
    c_double: cover property (os_r == OS_SECOND && mid);
endmodule : video_output_processing_chain

// *** core/video_chain_pkg.sv ***
// Functional notes
// - Edge position is the zero crossing of summed chroma second derivatives.
// - Edge region is where first-derivative magnitude exceeds the slope limit.
// - Edge region length is capped by the edge width cap.
// - Graphic mode keeps 1 to 4 bits, refilling low bits to keep level.
// - Each of Y, U, V has its own bit inversion control.
// - Line memory is written at input rate, read at the paced read rate.
// - Read rate is clamped between 3/4 and 4/3 of the write rate.
// - Read start address in the line is the programmable read offset.
// - Compander has an enable and a squeeze-or-stretch selector.
// - Interpolator gain is 65/64; output rate is at most double.
// - Without doubling, samples pass once at the plain rate.
// - Doubling without filter repeats each sample twice.
// - Blanking bypasses the compander; black value restores luma black.
// - Black value inserted for 80 clocks after delayed line sync.
// - Backdrop colour replaces pixels from start for width samples.
// - Backdrop may cross into next line but never over black phases.
// - Pattern key travels through compander; active key inserts pattern colour.
// - All insertions happen after the doubling stage.
// - Luma can be delayed by one output sample.
// - Each component gain can be halved independently.
// - Limiter clips every component to the 9-bit converter range.
// - Higher slope limit restricts sharpening to larger colour steps.
package video_chain_pkg;
    typedef logic [7:0] sample_t;
    typedef logic [8:0] dac_t;
    typedef logic [9:0] pos_t;
    typedef enum logic {OS_IDLE, OS_SECOND} os_state_t;
    localparam int BLACK_CLOCKS = 80;
    localparam logic [6:0] BLACK_LOAD = 7'(BLACK_CLOCKS);
    localparam logic [8:0] RATE_ONE = 9'h100;
    localparam logic [8:0] RATE_MIN = 9'h0C0;
    localparam logic [8:0] RATE_MAX = 9'h155;
    localparam int GAIN_SHIFT = 6;
    localparam sample_t CHROMA_ZERO = 8'h80;
    localparam dac_t OUT_MAX = 9'h1FF;
endpackage : video_chain_pkg

// *** tb/upstream_source.sv ***
`timescale 1ns/100ps
module upstream_source (
    input wire logic clock,
    output logic in_valid,
    output video_chain_pkg::sample_t in_y,
    output video_chain_pkg::sample_t in_u,
    output video_chain_pkg::sample_t in_v,
    output logic in_blank,
    output logic pattern_key,
    output logic line_sync
);
    import video_chain_pkg::*;
    initial begin
        in_valid = 1'b0;
        {in_y, in_u, in_v} = 24'h00_0000;
        in_blank = 1'b0;
        pattern_key = 1'b0;
        line_sync = 1'b0;
    end
    task automatic send(input sample_t y, u, v, input logic blank, key);
        @(negedge clock);
        in_valid = 1'b1;
        {in_y, in_u, in_v} = {y, u, v};
        in_blank = blank;
        pattern_key = key;
    endtask : send
    // Released lines must not look like a held sample
    task automatic idle();
        @(negedge clock);
        in_valid = 1'b0;
        {in_y, in_u, in_v} = ~{in_y, in_u, in_v};
        pattern_key = ~pattern_key;
    endtask : idle
    task automatic sync();
        @(negedge clock);
        line_sync = 1'b1;
        repeat (4) @(negedge clock);
        line_sync = 1'b0;
    endtask : sync
endmodule : upstream_source

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import video_chain_pkg::*;
    logic clock, rstn, in_valid, in_blank, pattern_key, line_sync, out_valid;
    sample_t in_y, in_u, in_v, slope_limit, line_sync_delay, black_value;
    sample_t backdrop_luma, backdrop_u, backdrop_v, pattern_luma, pattern_u, pattern_v;
    logic [3:0] edge_width_cap;
    logic [1:0] luma_graphic_bits, chroma_graphic_bits;
    logic luma_graphic_enable, chroma_graphic_enable, luma_invert, u_invert, v_invert;
    logic compander_enable, squeeze_stretch_enable, double_rate_enable;
    logic double_rate_filter_enable, backdrop_enable, pattern_key_polarity;
    logic luma_phase_trim, luma_half_gain, u_half_gain, v_half_gain;
    logic [8:0] read_step;
    pos_t read_offset, backdrop_start, backdrop_width;
    dac_t dac_y, dac_u, dac_v;
    int n_mismatch, compares, n_black, n_back, seed;
    sample_t y, u0, v0;
    logic [27:0] exp_q[$];
    upstream_source src (
        .clock(clock),
        .in_valid(in_valid),
        .in_y(in_y),
        .in_u(in_u),
        .in_v(in_v),
        .in_blank(in_blank),
        .pattern_key(pattern_key),
        .line_sync(line_sync)
    );
    video_output_processing_chain dut (.*);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    function automatic dac_t gn(input sample_t v, input logic h);
        gn = h ? {1'b0, v} : {v, 1'b0};
    endfunction : gn
    function automatic logic [26:0] ex(input sample_t y, u, v);
        ex = {gn(y, luma_half_gain), gn(u, u_half_gain), gn(v, v_half_gain)};
    endfunction : ex
    // Keep top n bits, refill the rest by repeating them
    function automatic sample_t qz(input sample_t v, input int n);
        for (int i = 7; i >= 0; i--) begin
            qz[i] = v[7 - ((7 - i) % n)];
        end
    endfunction : qz
    task automatic check(input logic [26:0] e, g);
        compares++;
        if (e !== g) begin
            n_mismatch++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : check
    task automatic want(input logic care, input logic [26:0] e);
        exp_q.push_back({care, e});
    endtask : want
    task automatic one(input sample_t y, u, v, input logic key, input logic [26:0] e);
        want(1'b1, e);
        src.send(y, u, v, 1'b0, key);
        src.idle();
        repeat (8) @(negedge clock);
    endtask : one
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    always @(negedge clock) begin
        logic [27:0] e;
        if (rstn === 1'b1 && out_valid === 1'b1) begin
            if ({dac_y, dac_u, dac_v} === ex(black_value, CHROMA_ZERO, CHROMA_ZERO)) begin
                n_black++;
            end
            if ({dac_y, dac_u, dac_v} === ex(backdrop_luma, backdrop_u, backdrop_v)) begin
                n_back++;
            end
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                if (e[27]) begin
                    check(e[26:0], {dac_y, dac_u, dac_v});
                end
            end
        end
    end
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        test_done();
    end
    initial begin
        seed = 32'h2d36_b8b0;
        rstn = 1'b0;
        {slope_limit, edge_width_cap} = {8'hc0, 4'h4};
        {luma_graphic_enable, chroma_graphic_enable} = 2'b00;
        {luma_graphic_bits, chroma_graphic_bits} = 4'h0;
        {luma_invert, u_invert, v_invert} = 3'b000;
        {compander_enable, squeeze_stretch_enable, read_step} = {2'b00, 9'h100};
        read_offset = 10'h000;
        {double_rate_enable, double_rate_filter_enable, luma_phase_trim} = 3'b000;
        {line_sync_delay, black_value} = {8'h64, 8'h10};
        backdrop_enable = 1'b0;
        {backdrop_luma, backdrop_u, backdrop_v} = 24'h60_40c0;
        {backdrop_start, backdrop_width} = {10'h005, 10'h12c};
        {pattern_luma, pattern_u, pattern_v} = 24'hd0_2050;
        pattern_key_polarity = 1'b0;
        {luma_half_gain, u_half_gain, v_half_gain} = 3'b111;
        v0 = 8'h90;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        for (int c = 0; c < 16; c++) begin
            {luma_invert, u_invert, v_invert, luma_half_gain} = c[3:0];
            {u_half_gain, v_half_gain} = {c[0] ^ c[1], ~c[2]};
            edge_width_cap = 4'($random(seed));
            u0 = 8'h60 + 8'($random(seed) & 31);
            for (int k = 0; k < 3; k++) begin
                y = 8'($random(seed));
                one(y, u0, v0, 1'b0, ex(luma_invert ? ~y : y, u_invert ? ~u0 : u0,
                    v_invert ? ~v0 : v0));
            end
        end
        $display("test gain and invert done");
        {luma_invert, u_invert, v_invert, luma_half_gain, u_half_gain, v_half_gain} = 6'h07;
        {luma_graphic_enable, chroma_graphic_enable} = 2'b11;
        for (int n = 0; n < 4; n++) begin
            {luma_graphic_bits, chroma_graphic_bits} = {2'(n), 2'(3 - n)};
            y = 8'($random(seed));
            one(y, u0, v0, 1'b0, ex(qz(y, n + 1), qz(u0, 4 - n), qz(v0, 4 - n)));
        end
        {luma_graphic_enable, chroma_graphic_enable} = 2'b00;
        $display("test graphic done");
        for (int p = 0; p < 2; p++) begin
            pattern_key_polarity = p[0];
            one(8'h33, u0, v0, ~p[0], ex(pattern_luma, pattern_u, pattern_v));
            one(8'h33, u0, v0, p[0], ex(8'h33, u0, v0));
        end
        $display("test pattern done");
        double_rate_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            y = 8'($random(seed));
            want(1'b1, ex(y, u0, v0));
            one(y, u0, v0, 1'b1, ex(y, u0, v0));
        end
        {double_rate_filter_enable, luma_half_gain} = 2'b10;
        for (int k = 0; k < 3; k++) begin
            want(k > 0, {9'h1ff, 9'h082, 9'h082});
            one(8'hff, 8'h80, 8'h80, 1'b1, {9'h1ff, 9'h082, 9'h082});
        end
        {double_rate_enable, double_rate_filter_enable, luma_half_gain} = 3'b001;
        $display("test double rate done");
        luma_phase_trim = 1'b1;
        want(1'b0, 27'h000_0000);
        want(1'b1, ex(8'h44, u0, v0));
        want(1'b1, ex(8'h55, u0, v0));
        src.send(8'h44, u0, v0, 1'b0, 1'b1);
        src.send(8'h55, u0, v0, 1'b0, 1'b1);
        src.send(8'h66, u0, v0, 1'b0, 1'b1);
        src.idle();
        repeat (8) @(negedge clock);
        luma_phase_trim = 1'b0;
        $display("test luma trim done");
        {compander_enable, pattern_key_polarity} = 2'b11;
        src.sync();
        for (int k = 0; k < 3; k++) begin
            y = 8'($random(seed));
            one(y, u0, v0, k[0], k[0] ? ex(y, u0, v0) : ex(pattern_luma, pattern_u, pattern_v));
        end
        compander_enable = 1'b0;
        $display("test compander done");
        backdrop_enable = 1'b1;
        src.sync();
        {n_black, n_back} = {32'd0, 32'd0};
        for (int k = 0; k < 400; k++) begin
            src.send(8'h20, 8'h80, 8'h80, 1'b0, 1'b1);
        end
        src.idle();
        repeat (10) @(negedge clock);
        check(27'(n_black), 27'd80);
        check(27'(n_back), 27'd220);
        $display("test black and backdrop done");
        test_done();
    end
endmodule : tb_top
